// [rtl/uamc_bit_timer.sv]
// Bit timer: counts enabled base ticks and pulses once per bit period
module uamc_bit_timer
    import uamc_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    // Control
    input  wire logic         clear,
    input  wire logic         restart,
    input  wire logic         half,
    input  wire logic         tick,
    input  wire logic [W-1:0] div,
    // Result
    output logic              expire
);
    logic [W-1:0] cnt_q;

    // Pulse on the tick taken while the count is one, the tick that reloads it
    assign expire = tick && (cnt_q == W'(1)) && !restart && !clear;

    // Reload on restart or expiry, half period for a centre sample
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (restart) begin
            cnt_q <= half ? (div >> 1) : div;
        end else if (tick) begin
            cnt_q <= (cnt_q <= W'(1)) ? div : cnt_q - W'(1);
        end
    end
endmodule // uamc_bit_timer

// [rtl/uamc_core.sv]
// Serial mode control, transmit/receive framing and receive error status
// Contract
// - Power bit low gates the operating clock and resets internal state asynchronously.
// - Power bit low drives transmit line high and reads receive line high.
// - After power-up the bit counter runs from the second base clock.
// - Transmit enable low stops transmission and holds transmitter in synchronous reset.
// - Receive enable low stops reception and holds receiver in synchronous reset.
// - Parity field: none, zero, odd, even for sending and checking.
// - Zero parity is never checked; no parity error or error interrupt.
// - Length bit selects seven or eight data bits both directions.
// - Stop bit setting selects one or two transmitted stop bits.
// - Reception always assumes a single stop bit.
// - Error select bit routes errored frames to error or completion interrupt.
// - Enabling reception while the line is low starts a frame.
// - Completed reception with mismatched parity sets the parity error flag.
// - Completed reception without stop bit sets the framing error flag.
// - Only the first stop bit position is checked for framing.
// - Completion while receive buffer is unread sets the overrun flag.
// - On overrun the new character is dropped, buffer kept.
// - Status read clears all error flags; so does power and receive disabled.
// - Reading the status register inserts one bus wait cycle.
module uamc_core
    import uamc_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Processor memory bus
    input  wire logic [15:0]      bus_addr,
    input  wire logic             bus_wr,
    input  wire logic             bus_rd,
    input  wire logic [7:0]       bus_wdata,
    output logic      [7:0]       bus_rdata,
    output logic                  bus_wait,
    // Base clock and bit rate from the clock selection logic
    input  wire logic             base_tick,
    input  wire logic [DIV_W-1:0] baud_div,
    // Transmit data path
    input  wire logic             tx_start,
    input  wire logic [7:0]       tx_data,
    output logic                  tx_busy,
    // Receive data path
    input  wire logic             rx_buffer_read,
    output logic      [7:0]       rx_buffer,
    output logic                  rx_buffer_full,
    // Interrupts
    output logic                  rx_complete_irq,
    output logic                  rx_error_irq,
    // Serial pins
    input  wire logic             serial_rx_line,
    output logic                  serial_tx_line
);
    uamc_mode_t  mode_q;
    uamc_err_t   err_q;
    logic        core_rst_n;
    logic [1:0]  run_cnt_q;
    logic        run_tick;
    logic        rx_sync1_q, rx_sync2_q;
    logic        rx_line;
    logic        status_rd;
    logic [2:0]  last_bit;
    uamc_state_t tx_state_q, rx_state_q;
    logic [7:0]  tx_shift_q, rx_shift_q;
    logic [2:0]  tx_bit_q, rx_bit_q;
    logic        tx_stop2_q, tx_par_q, rx_par_q;
    logic        tx_exp, rx_exp, rx_restart;
    logic        rx_done;
    uamc_err_t   rx_err;
    logic        rx_any_err;

    // Power bit acts as an asynchronous reset for all but the mode register, read data and receive synchroniser
    assign core_rst_n = arst_n & mode_q.power_enable;
    assign status_rd  = bus_rd && (bus_addr == UAMC_ADDR_STATUS);
    assign last_bit   = mode_q.char_length_select ? UAMC_LAST_BIT_8 : UAMC_LAST_BIT_7;

    // Mode register write; it survives power-down so software can re-enable
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= uamc_mode_t'(UAMC_MODE_RESET);
        end else if (bus_wr && bus_addr == UAMC_ADDR_MODE) begin
            mode_q <= uamc_mode_t'(bus_wdata);
        end
    end

    // Read data registered; status read stalls the bus for one cycle
    assign bus_wait = status_rd;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= UAMC_UNMAPPED;
        end else if (bus_rd) begin
            if (bus_addr == UAMC_ADDR_MODE) begin
                bus_rdata <= mode_q;
            end else if (status_rd) begin
                bus_rdata <= {5'h00, err_q};
            end else begin
                bus_rdata <= UAMC_UNMAPPED;
            end
        end
    end

    // Swallow the first base tick after power-up; counting starts on the second
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            run_cnt_q <= 2'h0;
        end else if (base_tick && run_cnt_q < UAMC_RUN_TICKS) begin
            run_cnt_q <= run_cnt_q + 2'h1;
        end
    end
    assign run_tick = base_tick && (run_cnt_q >= UAMC_RUN_TICKS);

    // Receive pin synchroniser, chip reset only so it never glitches on power toggles
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_sync1_q <= 1'b1;
            rx_sync2_q <= 1'b1;
        end else begin
            rx_sync1_q <= serial_rx_line;
            rx_sync2_q <= rx_sync1_q;
        end
    end
    assign rx_line = mode_q.power_enable ? rx_sync2_q : 1'b1;

    // Transmit bit timer, cleared while transmit is disabled
    uamc_bit_timer #(.W(DIV_W)) u_tx_timer (
        .ref_clk (ref_clk),
        .arst_n  (core_rst_n),
        .clear   (!mode_q.transmit_enable),
        .restart (tx_start && tx_state_q == UAMC_IDLE),
        .half    (1'b0),
        .tick    (run_tick),
        .div     (baud_div),
        .expire  (tx_exp)
    );

    // Transmit framer: start, data LSB first, optional parity, one or two stops
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            tx_state_q     <= UAMC_IDLE;
            serial_tx_line <= 1'b1;
            tx_shift_q     <= UAMC_BUF_RESET;
            tx_bit_q       <= 3'h0;
            tx_stop2_q     <= 1'b0;
            tx_par_q       <= 1'b0;
        end else if (!mode_q.transmit_enable) begin
            tx_state_q     <= UAMC_IDLE;
            serial_tx_line <= 1'b1;
        end else begin
            unique case (tx_state_q)
                UAMC_IDLE: begin
                    if (tx_start) begin
                        tx_shift_q     <= tx_data;
                        serial_tx_line <= 1'b0;
                        tx_bit_q       <= 3'h0;
                        tx_stop2_q     <= mode_q.stop_bits_select;
                        tx_par_q       <= 1'b0;
                        tx_state_q     <= UAMC_START;
                    end
                end
                UAMC_START, UAMC_DATA: begin
                    if (tx_exp) begin
                        serial_tx_line <= tx_shift_q[0];
                        tx_par_q       <= tx_par_q ^ tx_shift_q[0];
                        tx_shift_q     <= {1'b1, tx_shift_q[7:1]};
                        tx_state_q     <= UAMC_DATA;
                        if (tx_state_q == UAMC_DATA) begin
                            tx_bit_q <= tx_bit_q + 3'h1;
                        end
                        if (tx_state_q == UAMC_DATA && tx_bit_q == last_bit) begin
                            // Parity bit follows the data when enabled
                            unique case (mode_q.parity_select)
                                UAMC_PAR_NONE: serial_tx_line <= 1'b1;
                                UAMC_PAR_ZERO: serial_tx_line <= 1'b0;
                                UAMC_PAR_ODD:  serial_tx_line <= ~tx_par_q;
                                UAMC_PAR_EVEN: serial_tx_line <= tx_par_q;
                            endcase
                            tx_state_q <= (mode_q.parity_select == UAMC_PAR_NONE)
                                          ? UAMC_STOP : UAMC_PARITY;
                        end
                    end
                end
                UAMC_PARITY: begin
                    if (tx_exp) begin
                        serial_tx_line <= 1'b1;
                        tx_state_q     <= UAMC_STOP;
                    end
                end
                UAMC_STOP: begin
                    if (tx_exp) begin
                        if (tx_stop2_q) begin
                            tx_stop2_q <= 1'b0;
                        end else begin
                            tx_state_q <= UAMC_IDLE;
                        end
                    end
                end
                default: tx_state_q <= UAMC_IDLE;
            endcase
        end
    end
    assign tx_busy = (tx_state_q != UAMC_IDLE);

    // Receive bit timer, half period after start detection so samples sit mid-bit
    assign rx_restart = (rx_state_q == UAMC_IDLE) && !rx_line;
    uamc_bit_timer #(.W(DIV_W)) u_rx_timer (
        .ref_clk (ref_clk),
        .arst_n  (core_rst_n),
        .clear   (!mode_q.receive_enable),
        .restart (rx_restart),
        .half    (1'b1),
        .tick    (run_tick),
        .div     (baud_div),
        .expire  (rx_exp)
    );

    // Frame checks at the first stop position; later stops are ignored
    always_comb begin
        rx_done = (rx_state_q == UAMC_STOP) && rx_exp;
        rx_err.framing_error_flag = !rx_line;
        unique case (mode_q.parity_select)
            UAMC_PAR_ODD:  rx_err.parity_error_flag = ~(rx_par_q);
            UAMC_PAR_EVEN: rx_err.parity_error_flag = rx_par_q;
            default:       rx_err.parity_error_flag = 1'b0;
        endcase
        rx_err.overrun_error_flag = rx_buffer_full;
        rx_any_err = |rx_err;
    end

    // Receive framer; a false start (line high at mid start bit) is dropped
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            rx_state_q <= UAMC_IDLE;
            rx_shift_q <= 8'h00;
            rx_bit_q   <= 3'h0;
            rx_par_q   <= 1'b0;
        end else if (!mode_q.receive_enable) begin
            rx_state_q <= UAMC_IDLE;
        end else begin
            unique case (rx_state_q)
                UAMC_IDLE: begin
                    if (!rx_line) begin
                        rx_state_q <= UAMC_START;
                    end
                end
                UAMC_START: begin
                    if (rx_exp) begin
                        rx_state_q <= rx_line ? UAMC_IDLE : UAMC_DATA;
                        rx_bit_q   <= 3'h0;
                        rx_par_q   <= 1'b0;
                        rx_shift_q <= 8'h00;
                    end
                end
                UAMC_DATA: begin
                    if (rx_exp) begin
                        rx_shift_q[rx_bit_q] <= rx_line;
                        rx_par_q <= rx_par_q ^ rx_line;
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == last_bit) begin
                            rx_state_q <= (mode_q.parity_select == UAMC_PAR_NONE)
                                          ? UAMC_STOP : UAMC_PARITY;
                        end
                    end
                end
                UAMC_PARITY: begin
                    if (rx_exp) begin
                        rx_par_q   <= rx_par_q ^ rx_line;
                        rx_state_q <= UAMC_STOP;
                    end
                end
                UAMC_STOP: begin
                    if (rx_exp) begin
                        rx_state_q <= UAMC_IDLE;
                    end
                end
                default: rx_state_q <= UAMC_IDLE;
            endcase
        end
    end

    // Receive buffer; an overrun keeps the older character
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            rx_buffer      <= UAMC_BUF_RESET;
            rx_buffer_full <= 1'b0;
        end else if (rx_done && !rx_buffer_full) begin
            rx_buffer      <= rx_shift_q;
            rx_buffer_full <= 1'b1;
        end else if (rx_buffer_read) begin
            rx_buffer_full <= 1'b0;
        end
    end

    // Error flags: set by completion wins over a same-cycle status read
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            err_q <= uamc_err_t'(UAMC_STATUS_RESET);
        end else if (rx_done) begin
            err_q <= (status_rd ? uamc_err_t'(UAMC_STATUS_RESET) : err_q) | rx_err;
        end else if (status_rd || !mode_q.receive_enable) begin
            err_q <= uamc_err_t'(UAMC_STATUS_RESET);
        end
    end

    // Interrupt routing of errored frames, pulses in the completion cycle
    assign rx_complete_irq = rx_done && (!rx_any_err || mode_q.error_interrupt_select);
    assign rx_error_irq    = rx_done && rx_any_err && !mode_q.error_interrupt_select;
endmodule // uamc_core

// [rtl/uamc_pkg.sv]
// Package: register map, field layout and frame constants of the serial mode/error block
package uamc_pkg;
    // Register addresses on the processor memory bus
    localparam logic [15:0] UAMC_ADDR_MODE   = 16'hff50;
    localparam logic [15:0] UAMC_ADDR_STATUS = 16'hff53;
    // Reset values
    localparam logic [7:0]  UAMC_MODE_RESET   = 8'h01;
    localparam logic [7:0]  UAMC_STATUS_RESET = 8'h00;
    localparam logic [7:0]  UAMC_UNMAPPED     = 8'h00;
    // Mode register field positions
    localparam int UAMC_POS_POWER  = 7;
    localparam int UAMC_POS_TXE    = 6;
    localparam int UAMC_POS_RXE    = 5;
    localparam int UAMC_POS_PAR_HI = 4;
    localparam int UAMC_POS_PAR_LO = 3;
    localparam int UAMC_POS_LEN    = 2;
    localparam int UAMC_POS_STOP   = 1;
    localparam int UAMC_POS_ERRSEL = 0;
    // Status register field positions
    localparam int UAMC_POS_PE  = 2;
    localparam int UAMC_POS_FE  = 1;
    localparam int UAMC_POS_OVE = 0;
    // Parity field encodings
    localparam logic [1:0] UAMC_PAR_NONE = 2'h0;
    localparam logic [1:0] UAMC_PAR_ZERO = 2'h1;
    localparam logic [1:0] UAMC_PAR_ODD  = 2'h2;
    localparam logic [1:0] UAMC_PAR_EVEN = 2'h3;
    // Character lengths and timing counts
    localparam logic [2:0] UAMC_LAST_BIT_7 = 3'h6;
    localparam logic [2:0] UAMC_LAST_BIT_8 = 3'h7;
    localparam logic [1:0] UAMC_RUN_TICKS  = 2'h1; // base ticks swallowed after power-up
    localparam logic [7:0] UAMC_BUF_RESET  = 8'hff;

    // Operation mode register, bit 7 down to bit 0
    typedef struct packed {
        logic       power_enable;
        logic       transmit_enable;
        logic       receive_enable;
        logic [1:0] parity_select;
        logic       char_length_select;
        logic       stop_bits_select;
        logic       error_interrupt_select;
    } uamc_mode_t;

    // Receive error flags, bit 2 down to bit 0
    typedef struct packed {
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
    } uamc_err_t;

    typedef enum logic [2:0] {
        UAMC_IDLE, UAMC_START, UAMC_DATA, UAMC_PARITY, UAMC_STOP
    } uamc_state_t;
endpackage : uamc_pkg

// [tb/test_uamc_core.sv]
// Testbench: registers, framing, error flags and power control of the serial core
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_uamc_core
    import uamc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DIV = 8;
    logic        ref_clk, arst_n, bus_wr, bus_rd, base_tick, tx_start, rx_buffer_read;
    logic        bus_wait, tx_busy, rx_buffer_full, rx_complete_irq, rx_error_irq;
    logic        serial_rx_line, serial_tx_line;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, baud_div, tx_data, rx_buffer;
    logic [31:0] lfsr_q;
    int          err_count, compares, n_ok, n_bad;
    // Core and far-end node
    uamc_core i_uamc_core (
        .ref_clk, .arst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_wait,
        .base_tick, .baud_div, .tx_start, .tx_data, .tx_busy, .rx_buffer_read, .rx_buffer,
        .rx_buffer_full, .rx_complete_irq, .rx_error_irq, .serial_rx_line, .serial_tx_line
    );
    uamc_remote_node #(.BIT_CYC(DIV)) i_uamc_remote_node (
        .ref_clk, .to_dut(serial_rx_line), .from_dut(serial_tx_line)
    );
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Completion pulses counted by kind
    always @(posedge ref_clk) begin
        if (rx_complete_irq === 1'b1) n_ok++;
        if (rx_error_irq === 1'b1) n_bad++;
    end
    // Line bits of one frame, LSB first; returns the bit count
    function automatic int frame(input logic [7:0] d, input uamc_mode_t m, input logic flip,
                                 input logic bad_stop, input int stops, output logic [12:0] f);
        int         n;
        logic [7:0] dm;
        dm = m.char_length_select ? d : {1'b0, d[6:0]};
        n = m.char_length_select ? 9 : 8;
        f = {4'hf, dm, 1'b0};
        if (m.parity_select != UAMC_PAR_NONE) begin
            f[n] = flip ^ (m.parity_select == UAMC_PAR_ODD ? ~^dm :
                           m.parity_select == UAMC_PAR_EVEN ? ^dm : 1'b0);
            n++;
        end
        f[n] = !bad_stop;
        return n + stops;
    endfunction
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Bus cycles: strobe for one edge; write data goes with the strobe, read data is taken one cycle later
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #2 bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge ref_clk);
        #2 bus_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #2 bus_addr = a;
        bus_rd = 1'b1;
        @(posedge ref_clk);
        #2 bus_rd = 1'b0;
        d = bus_rdata;
    endtask
    task automatic chk_status(input logic [7:0] exp);
        logic [7:0] got;
        rd(UAMC_ADDR_STATUS, got);
        `CHK(got, exp)
    endtask
    task automatic pulse_read();
        @(posedge ref_clk);
        #2 rx_buffer_read = 1'b1;
        @(posedge ref_clk);
        #2 rx_buffer_read = 1'b0;
    endtask
    // Directions off before the format changes; power bit kept, then set on with the format
    task automatic set_mode(input uamc_mode_t m);
        logic [7:0] c;
        rd(UAMC_ADDR_MODE, c);
        wr(UAMC_ADDR_MODE, {c[7], 2'b00, c[4:0]});
        wr(UAMC_ADDR_MODE, {3'b100, m[4:0]});
        wr(UAMC_ADDR_MODE, m);
    endtask
    task automatic rx_one(input uamc_mode_t m, input logic [7:0] d, input logic flip,
                          input logic bad, input int dok, input int dbad);
        logic [12:0] f;
        int          ok0, bad0, n;
        ok0 = n_ok;
        bad0 = n_bad;
        n = frame(d, m, flip, bad, 1, f);
        i_uamc_remote_node.send(f, n);
        repeat (4) @(posedge ref_clk);
        `CHK(n_ok - ok0, dok)
        `CHK(n_bad - bad0, dbad)
    endtask
    task automatic end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog, well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end
    // Main sequence
    initial begin
        uamc_mode_t  m;
        logic [7:0]  d;
        logic [12:0] f, cap;
        int          n, busy;
        {bus_addr, bus_wdata, tx_data, bus_wr, bus_rd, tx_start, rx_buffer_read} = '0;
        base_tick = 1'b1;
        baud_div = 8'(DIV);
        lfsr_q = 32'hdf888874;
        arst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #2 arst_n = 1'b1;
        rd(UAMC_ADDR_MODE, d);
        `CHK(d, UAMC_MODE_RESET)
        wr(UAMC_ADDR_STATUS, 8'hff);
        chk_status(UAMC_STATUS_RESET);
        rd(16'hff51, d);
        `CHK(d, UAMC_UNMAPPED)
        `CHK(serial_tx_line, 1'b1)
        `CHK(rx_buffer, UAMC_BUF_RESET)
        // Every parity code at both lengths, random data and stop setting
        for (int k = 0; k < 8; k++) begin
            lfsr_q = next_rand(lfsr_q);
            d = lfsr_q[7:0];
            m = {3'b111, k[2:1], k[0], lfsr_q[8], 1'b0};
            set_mode(m);
            rx_one(m, d, 1'b0, 1'b0, 1, 0);
            `CHK(rx_buffer, m.char_length_select ? d : {1'b0, d[6:0]})
            chk_status(UAMC_STATUS_RESET);
            pulse_read();
            n = frame(d, m, 1'b0, 1'b0, m.stop_bits_select ? 2 : 1, f);
            busy = 0;
            fork
                i_uamc_remote_node.capture(n, cap);
                begin
                    @(posedge ref_clk iff tx_busy === 1'b1);
                    while (tx_busy === 1'b1) begin
                        busy++;
                        @(posedge ref_clk);
                    end
                end
                begin
                    @(posedge ref_clk);
                    #2 tx_data = d;
                    tx_start = 1'b1;
                    @(posedge ref_clk);
                    #2 tx_start = 1'b0;
                end
            join
            `CHK(cap, f & 13'((1 << n) - 1))
            `CHK(busy, n * DIV)
        end
        // Odd parity broken, error interrupt selected
        m = {3'b111, UAMC_PAR_ODD, 3'b100};
        set_mode(m);
        rx_one(m, 8'h5a, 1'b1, 1'b0, 0, 1);
        chk_status(8'h04);
        chk_status(UAMC_STATUS_RESET);
        pulse_read();
        // Zero parity: a wrong parity bit passes unnoticed
        m.parity_select = UAMC_PAR_ZERO;
        set_mode(m);
        rx_one(m, 8'h3c, 1'b1, 1'b0, 1, 0);
        chk_status(UAMC_STATUS_RESET);
        pulse_read();
        // Missing stop bit routed to the normal completion
        m.parity_select = UAMC_PAR_NONE;
        m.error_interrupt_select = 1'b1;
        set_mode(m);
        rx_one(m, 8'hc3, 1'b0, 1'b1, 1, 0);
        chk_status(8'h02);
        pulse_read();
        // Two single-stop frames, the first left unread: overrun
        m.stop_bits_select = 1'b1;
        set_mode(m);
        rx_one(m, 8'h11, 1'b0, 1'b0, 1, 0);
        rx_one(m, 8'h22, 1'b0, 1'b0, 1, 0);
        `CHK(rx_buffer, 8'h11)
        chk_status(8'h01);
        // Directions off, then power off
        wr(UAMC_ADDR_MODE, {3'b100, m[4:0]});
        wr(UAMC_ADDR_MODE, 8'h00);
        `CHK(rx_buffer, UAMC_BUF_RESET)
        `CHK(rx_buffer_full, 1'b0)
        `CHK(serial_tx_line, 1'b1)
        // Ticks held over power-up, so the first one is swallowed
        base_tick = 1'b0;
        set_mode(m);
        @(posedge ref_clk);
        #2 tx_data = 8'hff;
        tx_start = 1'b1;
        @(posedge ref_clk);
        #2 tx_start = 1'b0;
        base_tick = 1'b1;
        repeat (DIV) @(posedge ref_clk);
        #2 `CHK(serial_tx_line, 1'b0)
        @(posedge ref_clk);
        #2 `CHK(serial_tx_line, 1'b1)
        end_of_test();
    end
endmodule // test_uamc_core

// [tb/uamc_core_properties.sv]
// Checker: port-level properties of the serial mode and error core
module uamc_core_properties
    import uamc_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        arst_n,
    // Register bus
    input wire logic [15:0] bus_addr,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        bus_wait,
    // Data paths and pins
    input wire logic        tx_busy,
    input wire logic [7:0]  rx_buffer,
    input wire logic        rx_buffer_full,
    input wire logic        rx_complete_irq,
    input wire logic        rx_error_irq,
    input wire logic        serial_tx_line
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    uamc_mode_t mode_q;
    logic       clean_q;
    logic       st_rd;
    logic       irq;
    assign st_rd = bus_rd && bus_addr == UAMC_ADDR_STATUS;
    assign irq   = rx_complete_irq || rx_error_irq;
    // Mode shadow; clean means flags were read with no completion since
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q  <= UAMC_MODE_RESET;
            clean_q <= 1'b0;
        end else begin
            if (bus_wr && bus_addr == UAMC_ADDR_MODE) mode_q <= bus_wdata;
            clean_q <= !irq && (st_rd || clean_q);
        end
    end
    property p_power_off;
        !mode_q.power_enable |-> serial_tx_line && !rx_buffer_full && rx_buffer == UAMC_BUF_RESET;
    endproperty
    a_power_off: assert property (p_power_off) else $error("idle state lost while off");
    property p_wait; bus_wait == st_rd; endproperty
    a_wait: assert property (p_wait) else $error("wait cycle wrong");
    property p_route;
        irq |-> !(rx_complete_irq && rx_error_irq) && !(mode_q.error_interrupt_select && rx_error_irq);
    endproperty
    a_route: assert property (p_route) else $error("interrupt routing wrong");
    property p_rx_off; !mode_q.receive_enable |-> !irq; endproperty
    a_rx_off: assert property (p_rx_off) else $error("reception while disabled");
    property p_tx_off;
        !mode_q.transmit_enable && !$past(mode_q.transmit_enable) |-> !tx_busy && serial_tx_line;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("transmission while disabled");
    property p_read_clears; st_rd && clean_q && !irq |=> bus_rdata == UAMC_STATUS_RESET; endproperty
    a_read_clears: assert property (p_read_clears) else $error("flags not cleared");
    property p_zero;
        st_rd && mode_q.parity_select == UAMC_PAR_ZERO |=> !bus_rdata[UAMC_POS_PE];
    endproperty
    a_zero: assert property (p_zero) else $error("parity flag under zero parity");
    property p_overrun; irq && rx_buffer_full |=> rx_buffer_full && $stable(rx_buffer); endproperty
    a_overrun: assert property (p_overrun) else $error("buffer overwritten");
endmodule // uamc_core_properties

bind uamc_core uamc_core_properties u_props (
    .ref_clk, .arst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_wait,
    .tx_busy, .rx_buffer, .rx_buffer_full, .rx_complete_irq, .rx_error_irq, .serial_tx_line
);

// [tb/uamc_remote_node.sv]
// Remote serial node: sends frames to the core and captures frames from it
module uamc_remote_node #(
    parameter int BIT_CYC = 8
) (
    // Clock
    input  wire logic ref_clk,
    // Serial pins seen from the far end
    output logic      to_dut,
    input  wire logic from_dut
);
    timeunit 1ns;
    timeprecision 100ps;
    // Line rests high, as its pull-up holds it
    initial to_dut = 1'b1;
    // LSB first, one bit time each, then a full idle bit
    task automatic send(input logic [12:0] bits, input int n);
        for (int i = 0; i <= n; i++) begin
            @(posedge ref_clk);
            #2 to_dut = (i < n) ? bits[i] : 1'b1;
            repeat (BIT_CYC - 1) @(posedge ref_clk);
        end
    endtask
    // Mid-bit sampling from the start edge
    task automatic capture(input int n, output logic [12:0] bits);
        bits = '0;
        @(negedge from_dut);
        repeat (BIT_CYC / 2) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            bits[i] = from_dut;
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask
endmodule // uamc_remote_node
